// [framer_status_interrupt.v]
// Latched status, alarm change detect and interrupt logic for one framer port
`timescale 1ns/1ps
`default_nettype none
`include "framer_status_interrupt_regs.vh"

// Function
// - Four status and information registers exist and a bit goes to 1 when its event occurs or its alarm is present.
// - Bits of status one, status two and receive info latch until a write of 1 to a bit read as 1 clears them; alarm and repeater bits set again while present.
// - The four alarm bits stay set after a read while their alarm is still present.
// - A written 1 makes the readable copy of that bit load the latest condition.
// - A written 0 makes the readable copy of that bit hold its previous value.
// - The sync status register is read-only, unlatched, real time and needs no mask write.
// - Only status one and two bits drive the interrupt, each masked by its own mask bit.
// - Each alarm raises the interrupt on every change of state, up or down.
// - Reading the alarm bit that raised the interrupt releases it even if the alarm persists.
// - An event raises the interrupt and reading the event bit releases it.
// - Repeating events raise the interrupt again each time they occur.
// - One-shot events raise the interrupt only on first detection of the condition.
// - The prbs detect source fires once, re-arms on loss of pattern, and fires on next detect.
module framer_status_interrupt #(
  parameter WIDTH = 8
) (
  input  wire             clk_i,
  input  wire             rst_i,
  // Classic Wishbone slave
  input  wire             wb_cyc_i,
  input  wire             wb_stb_i,
  input  wire             wb_we_i,
  input  wire [5:0]       wb_adr_i,
  input  wire [3:0]       wb_sel_i,
  input  wire [31:0]      wb_dat_i,
  output reg  [31:0]      wb_dat_o,
  output reg              wb_ack_o,
  // Conditions from the framer, asynchronous to the bus clock
  input  wire [WIDTH-1:0] status_one_src_i,
  input  wire [WIDTH-1:0] status_two_src_i,
  input  wire [WIDTH-1:0] rx_info_src_i,
  input  wire [WIDTH-1:0] sync_status_src_i,
  // Outputs
  output wire             int_n_o,
  output wire             irq_o
);

  // Two-flop synchronisers for all framer inputs
  reg [WIDTH-1:0] s1_meta_q, s1_sync_q, s1_prev_q;
  reg [WIDTH-1:0] s2_meta_q, s2_sync_q, s2_prev_q;
  reg [WIDTH-1:0] ri_meta_q, ri_sync_q, ri_prev_q;
  reg [WIDTH-1:0] ss_meta_q, ss_sync_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      s1_meta_q <= `RESET_BYTE;
      s1_sync_q <= `RESET_BYTE;
      s1_prev_q <= `RESET_BYTE;
      s2_meta_q <= `RESET_BYTE;
      s2_sync_q <= `RESET_BYTE;
      s2_prev_q <= `RESET_BYTE;
      ri_meta_q <= `RESET_BYTE;
      ri_sync_q <= `RESET_BYTE;
      ri_prev_q <= `RESET_BYTE;
      ss_meta_q <= `RESET_BYTE;
      ss_sync_q <= `RESET_BYTE;
    end else begin
      s1_meta_q <= status_one_src_i;
      s1_sync_q <= s1_meta_q;
      s1_prev_q <= s1_sync_q;
      s2_meta_q <= status_two_src_i;
      s2_sync_q <= s2_meta_q;
      s2_prev_q <= s2_sync_q;
      ri_meta_q <= rx_info_src_i;
      ri_sync_q <= ri_meta_q;
      ri_prev_q <= ri_sync_q;
      ss_meta_q <= sync_status_src_i;
      ss_sync_q <= ss_meta_q;
    end
  end

  // Bus decode; ack is given one cycle after the strobe and dropped next
  wire bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr    = bus_req & wb_we_i & wb_sel_i[0];
  wire bus_rd    = bus_req & ~wb_we_i;
  wire [7:0] wbyte = wb_dat_i[7:0];

  wire wr_s1 = bus_wr & (wb_adr_i == `ADDR_STATUS_ONE);
  wire wr_s2 = bus_wr & (wb_adr_i == `ADDR_STATUS_TWO);
  wire wr_ri = bus_wr & (wb_adr_i == `ADDR_RX_INFO);
  wire rd_s1 = bus_rd & (wb_adr_i == `ADDR_STATUS_ONE);
  wire rd_s2 = bus_rd & (wb_adr_i == `ADDR_STATUS_TWO);
  wire rd_ri = bus_rd & (wb_adr_i == `ADDR_RX_INFO);

  // Hidden latches collect conditions; readable copies load on mask write
  reg [WIDTH-1:0] s1_latch_q, s2_latch_q, ri_latch_q;
  reg [WIDTH-1:0] s1_read_q, s2_read_q, ri_read_q;
  reg [WIDTH-1:0] s1_pend_q, s2_pend_q;
  reg [WIDTH-1:0] irq_mask_one_q, irq_mask_two_q;

  // Set terms: level for alarms, rising edge for one-shots, level for repeaters
  wire [WIDTH-1:0] s1_rise = s1_sync_q & ~s1_prev_q;
  wire [WIDTH-1:0] s2_rise = s2_sync_q & ~s2_prev_q;
  wire [WIDTH-1:0] ri_rise = ri_sync_q & ~ri_prev_q;
  wire [WIDTH-1:0] s1_set  = (s1_sync_q & ~`ONE_SHOT_MASK_ONE) |
                             (s1_rise & `ONE_SHOT_MASK_ONE);
  wire [WIDTH-1:0] s2_set  = (s2_sync_q & ~`ONE_SHOT_MASK_TWO) |
                             (s2_rise & `ONE_SHOT_MASK_TWO);
  // Alarm change in either direction raises a pending interrupt
  wire [WIDTH-1:0] s1_chg  = (s1_sync_q ^ s1_prev_q) & `ALARM_MASK;
  wire [WIDTH-1:0] s1_pset = (s1_set & ~`ALARM_MASK) | s1_chg;

  // Read and write-back clear: bits read out as 1 on a write of 1 clear
  wire [WIDTH-1:0] s1_clr = wr_s1 ? (wbyte & s1_read_q) : `RESET_BYTE;
  wire [WIDTH-1:0] s2_clr = wr_s2 ? (wbyte & s2_read_q) : `RESET_BYTE;
  wire [WIDTH-1:0] ri_clr = wr_ri ? (wbyte & ri_read_q) : `RESET_BYTE;

  // Latch and readable-copy update, set wins over clear
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk_i) begin
        if (rst_i) begin
          s1_latch_q[i] <= 1'b0;
          s2_latch_q[i] <= 1'b0;
          ri_latch_q[i] <= 1'b0;
          s1_read_q[i]  <= 1'b0;
          s2_read_q[i]  <= 1'b0;
          ri_read_q[i]  <= 1'b0;
          s1_pend_q[i]  <= 1'b0;
          s2_pend_q[i]  <= 1'b0;
        end else begin
          s1_latch_q[i] <= s1_set[i] | (s1_latch_q[i] & ~s1_clr[i]);
          s2_latch_q[i] <= s2_set[i] | (s2_latch_q[i] & ~s2_clr[i]);
          ri_latch_q[i] <= ri_rise[i] | (ri_latch_q[i] & ~ri_clr[i]);
          // Written 1 loads latest, written 0 holds
          if (wr_s1 & wbyte[i])
            s1_read_q[i] <= s1_latch_q[i];
          else
            s1_read_q[i] <= s1_read_q[i];
          if (wr_s2 & wbyte[i])
            s2_read_q[i] <= s2_latch_q[i];
          if (wr_ri & wbyte[i])
            ri_read_q[i] <= ri_latch_q[i];
          // Pending clears when the host reads its bit as set
          s1_pend_q[i] <= s1_pset[i] |
                          (s1_pend_q[i] & ~(rd_s1 & s1_read_q[i]));
          s2_pend_q[i] <= s2_set[i] |
                          (s2_pend_q[i] & ~(rd_s2 & s2_read_q[i]));
        end
      end
    end
  endgenerate

  // Interrupt: only status one and two, each bit masked
  wire grp_one = |(s1_pend_q & irq_mask_one_q);
  wire grp_two = |(s2_pend_q & irq_mask_two_q);
  assign int_n_o = ~(grp_one | grp_two);

  // Block interrupt status, rising edge of each group sets the sticky bit
  reg [`IRQ_WIDTH-1:0] irq_stat_q, irq_en_q, grp_prev_q;
  wire [`IRQ_WIDTH-1:0] grp_now = {grp_two, grp_one};
  wire [`IRQ_WIDTH-1:0] irq_clr = (bus_wr & (wb_adr_i == `ADDR_IRQ_CLEAR)) ?
                                  wbyte[`IRQ_WIDTH-1:0] : `RESET_IRQ;
  wire [`IRQ_WIDTH-1:0] irq_set = grp_now & ~grp_prev_q;
  assign irq_o = |(irq_stat_q & irq_en_q);

  // Mask and interrupt registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_one_q <= `RESET_BYTE;
      irq_mask_two_q <= `RESET_BYTE;
      irq_stat_q     <= `RESET_IRQ;
      irq_en_q       <= `RESET_IRQ;
      grp_prev_q     <= `RESET_IRQ;
    end else begin
      grp_prev_q <= grp_now;
      irq_stat_q <= irq_set | (irq_stat_q & ~irq_clr);
      if (bus_wr & (wb_adr_i == `ADDR_MASK_ONE))
        irq_mask_one_q <= wbyte;
      if (bus_wr & (wb_adr_i == `ADDR_MASK_TWO))
        irq_mask_two_q <= wbyte;
      if (bus_wr & (wb_adr_i == `ADDR_IRQ_ENABLE))
        irq_en_q <= wbyte[`IRQ_WIDTH-1:0];
    end
  end

  // Read mux; unmapped addresses read zero and still ack
  reg [7:0] rdata;
  always @* begin
    case (wb_adr_i)
      `ADDR_STATUS_ONE:  rdata = s1_read_q;
      `ADDR_STATUS_TWO:  rdata = s2_read_q;
      `ADDR_RX_INFO:     rdata = ri_read_q;
      `ADDR_SYNC_STATUS: rdata = ss_sync_q;
      `ADDR_MASK_ONE:    rdata = irq_mask_one_q;
      `ADDR_MASK_TWO:    rdata = irq_mask_two_q;
      `ADDR_IRQ_STATUS:  rdata = {6'h00, irq_stat_q};
      `ADDR_IRQ_ENABLE:  rdata = {6'h00, irq_en_q};
      default:           rdata = `RESET_BYTE;
    endcase
  end

  // Bus answer registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_rd)
        wb_dat_o <= {24'h000000, rdata};
    end
  end

endmodule // framer_status_interrupt
`default_nettype wire

// [framer_status_interrupt_regs.vh]
// Register map and field layout for the framer status and interrupt block
`ifndef FRAMER_STATUS_INTERRUPT_REGS_VH
`define FRAMER_STATUS_INTERRUPT_REGS_VH

// Byte addresses on the 32-bit Wishbone bus
`define ADDR_STATUS_ONE   6'h00
`define ADDR_STATUS_TWO   6'h04
`define ADDR_RX_INFO      6'h08
`define ADDR_SYNC_STATUS  6'h0c
`define ADDR_MASK_ONE     6'h10
`define ADDR_MASK_TWO     6'h14
`define ADDR_IRQ_STATUS   6'h18
`define ADDR_IRQ_CLEAR    6'h1c
`define ADDR_IRQ_ENABLE   6'h20

// Status one layout: low nibble holds the four alarms
`define ALARM_MASK        8'h0f
`define IDX_ALARM_LSB     0
`define IDX_ALARM_MSB     3
// Status one bits 7..4: sig all ones, distant mf alarm, sig all zeros, slip
// Status two bits: 7 rx mf, 6 tx mf, 5 second, 4 tx align, 3 rx align,
// 2 tx clock lost, 1 prbs detect, 0 rx crc mf
`define ONE_SHOT_MASK_ONE 8'he0
`define ONE_SHOT_MASK_TWO 8'h06

// Block interrupt bits
`define IRQ_BIT_ONE       0
`define IRQ_BIT_TWO       1
`define IRQ_WIDTH         2

`define RESET_BYTE        8'h00
`define RESET_IRQ         2'h0

`endif

// [framer_status_interrupt_chk.sv]
// Bus and interrupt assertions for the framer status interrupt block
`timescale 1ns/1ps
`default_nettype none
module framer_status_interrupt_chk #(
  parameter WIDTH = 8
) (
  input wire        clk_i,
  input wire        rst_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        int_n_o,
  input wire        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request taken and its single-cycle answer
  sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence ack_s; wb_ack_o ##1 !wb_ack_o; endsequence
  a_ack_follows_req: assert property (req_s |=> ack_s) else $error("ack missing");
  a_ack_has_req: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_upper_zero: assert property (wb_dat_o[31:8] == 24'h0) else $error("upper data");
  a_dat_on_read: assert property ($changed(wb_dat_o) |-> wb_ack_o && $past(!wb_we_i))
    else $error("read data moved");
  // Interrupt only released by bus activity, never by the source going away
  a_int_release_read: assert property ($rose(int_n_o) |->
    wb_ack_o || $past(wb_ack_o) || $past(wb_ack_o, 2)) else $error("int released");
  a_int_hold_idle: assert property (!int_n_o && !wb_cyc_i && !wb_ack_o |=> !int_n_o)
    else $error("int dropped idle");
  a_irq_rise_cause: assert property ($rose(irq_o) |-> $past(!int_n_o) || wb_ack_o)
    else $error("irq rose");
  a_irq_fall_write: assert property ($fell(irq_o) |-> wb_ack_o && $past(wb_we_i))
    else $error("irq fell");
endmodule // framer_status_interrupt_chk
bind framer_status_interrupt framer_status_interrupt_chk #(.WIDTH(WIDTH)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .int_n_o(int_n_o),
  .irq_o(irq_o));
`default_nettype wire

// [wb_host_model.sv]
// Host processor model issuing classic Wishbone cycles
`timescale 1ns/1ps
`default_nettype none
module wb_host_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [5:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o
);
  int timeouts = 0;
  initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  // Hold the request until ack is sampled, then release; never assumes latency
  task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
                      output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, 4'hf, 24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 50);
    if (n >= 50) timeouts++;
    r = dat_i[7:0];
    {cyc_o, stb_o} <= 2'b00;
  endtask
  // Mask write, read, masked write-back so only chosen bits clear
  task automatic poll(input logic [5:0] a, input logic [7:0] m, output logic [7:0] r);
    logic [7:0] x;
    xfer(1'b1, a, m, x);
    xfer(1'b0, a, 8'h00, r);
    xfer(1'b1, a, r & m, x);
  endtask
endmodule // wb_host_model
`default_nettype wire

// [framer_status_interrupt_tb_top.sv]
// Self-checking bench for the framer status interrupt block
`timescale 1ns/1ps
`default_nettype none
module framer_status_interrupt_tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc, stb, we, ack, int_n, irq;
  logic [7:0] s1 = 8'h00, s2 = 8'h00, ri = 8'h00, ss = 8'h00, r;
  logic [5:0] adr;
  logic [3:0] sel;
  logic [31:0] dw, dr;
  int errors = 0, samples_checked = 0;
  initial forever #5 clk_i = ~clk_i;
  framer_status_interrupt dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr),
    .wb_ack_o(ack), .status_one_src_i(s1), .status_two_src_i(s2), .rx_info_src_i(ri),
    .sync_status_src_i(ss), .int_n_o(int_n), .irq_o(irq));
  wb_host_model host (.clk_i(clk_i), .ack_i(ack), .dat_i(dr), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(dw));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: byte %h want %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk({7'h0, g}, {7'h0, e});
  endtask
  // Sources cross two sync stages, so give them time before looking
  task automatic settle;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic wait_int(input logic lvl);
    int n;
    n = 0;
    while (int_n !== lvl && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    chk1(int_n, lvl);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    host.xfer(1'b0, a, 8'h00, r);
    chk(r, e);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d, r);
  endtask
  task automatic end_of_test;
    errors += host.timeouts;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk1(int_n, 1'b1);
    rd(6'h00, 8'h00);
    rd(6'h24, 8'h00);
    ss <= 8'h5a;
    settle;
    wr(6'h0c, 8'hff);
    rd(6'h0c, 8'h5a);
    // Alarm interrupts on both edges, bit stays set while present
    wr(6'h10, 8'h01);
    s1 <= 8'h01;
    wait_int(1'b0);
    settle;
    chk1(irq, 1'b0);
    rd(6'h18, 8'h01);
    rd(6'h10, 8'h01);
    wr(6'h20, 8'h03);
    chk1(irq, 1'b1);
    wr(6'h1c, 8'h03);
    chk1(irq, 1'b0);
    rd(6'h18, 8'h00);
    host.poll(6'h00, 8'h01, r); chk(r, 8'h01);
    wait_int(1'b1);
    settle;
    host.poll(6'h00, 8'h01, r); chk(r, 8'h01);
    s1 <= 8'h00;
    wait_int(1'b0);
    host.poll(6'h00, 8'h01, r); chk(r, 8'h01);
    wait_int(1'b1);
    host.poll(6'h00, 8'h01, r); chk(r, 8'h00);
    // Masked slip event: a zero mask holds the readable copy
    s1 <= 8'h10;
    settle;
    s1 <= 8'h00;
    chk1(int_n, 1'b1);
    settle;
    host.poll(6'h00, 8'h10, r); chk(r, 8'h10);
    wr(6'h00, 8'h00);
    rd(6'h00, 8'h10);
    // One-shot pattern detect fires once and re-arms on loss
    wr(6'h14, 8'h02);
    s2 <= 8'h02;
    wait_int(1'b0);
    host.poll(6'h04, 8'h02, r); chk(r, 8'h02);
    wait_int(1'b1);
    settle;
    chk1(int_n, 1'b1);
    s2 <= 8'h00;
    settle;
    s2 <= 8'h02;
    wait_int(1'b0);
    host.poll(6'h04, 8'h02, r);
    wait_int(1'b1);
    // Repeating second tick keeps firing while held
    wr(6'h14, 8'h20);
    s2 <= 8'h22;
    wait_int(1'b0);
    host.poll(6'h04, 8'h20, r); chk(r, 8'h20);
    settle;
    chk1(int_n, 1'b0);
    s2 <= 8'h02;
    settle;
    host.poll(6'h04, 8'h20, r);
    wait_int(1'b1);
    // Receive info latches but never interrupts
    ri <= 8'h04;
    settle;
    ri <= 8'h00;
    chk1(int_n, 1'b1);
    settle;
    host.poll(6'h08, 8'h04, r); chk(r, 8'h04);
    end_of_test;
  end
endmodule // framer_status_interrupt_tb_top
`default_nettype wire
